/* logic/flr_op_timer.v */
// Purpose: times one flash write, erase or lock-bit write
// Assumes: pclk is the calibrated oscillator clock
// Notes:   runs on power-on reset only so a system reset cannot cut a write short
`timescale 1ns/100ps
`include "flr_regs.vh"

module flr_op_timer #(
    parameter CYCLES = `FLR_WR_CYCLES
) (
    input  wire        pclk,
    input  wire        por_n,
    input  wire        start,
    output reg         busy,
    output reg         done
);

    reg  [19:0] count;

    // ****************************************
    // count down; done pulses in the first cycle after busy drops
    // ****************************************
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= 20'h00000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                count <= CYCLES[19:0] - 20'h00001; // see R16
            end else if (busy) begin
                if (count == 20'h00000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 20'h00001;
                end
            end
        end
    end

endmodule // flr_op_timer

/* logic/flr_regs.vh */
// Purpose: shared constants of the fuse, lock and signature read-back unit
// Assumes: 100 MHz pclk, APB byte addresses, one register per aligned word
// Notes:   definitions only
`ifndef FLR_REGS_VH
`define FLR_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define FLR_OFS_CTRL      8'h00
`define FLR_OFS_PTR       8'h04
`define FLR_OFS_LOAD      8'h08
`define FLR_OFS_STORE     8'h0C
`define FLR_OFS_RESULT    8'h10
`define FLR_OFS_STATUS    8'h14

// ****************************************
// control register fields
// ****************************************
`define FLR_B_SPEN        0
`define FLR_B_ERASE       1
`define FLR_B_WRITE       2
`define FLR_B_LFSEL       3
`define FLR_B_RWWRE       4
`define FLR_B_SIGSEL      5
`define FLR_B_RWWBUSY     6
`define FLR_CTRL_RST      8'h00

// ****************************************
// pointer codes
// ****************************************
`define FLR_PTR_FUSE_LOW  16'h0000
`define FLR_PTR_LOCK      16'h0001
`define FLR_PTR_FUSE_EXT  16'h0002
`define FLR_PTR_FUSE_HIGH 16'h0003
`define FLR_PTR_SIG1      16'h0000
`define FLR_PTR_CAL       16'h0001
`define FLR_PTR_SIG2      16'h0002
`define FLR_PTR_SIG3      16'h0004

// ****************************************
// field masks and fill values
// ****************************************
`define FLR_LOCK_FILL     8'hC0
`define FLR_EXT_FILL      8'hF8
`define FLR_BLANK         8'hFF
`define FLR_LOCK_RST      6'h3F

// ****************************************
// timing
// ****************************************
`define FLR_LOAD_WIN      3'h3
`define FLR_STORE_WIN     3'h4
`define FLR_CLK_NS        10
`define FLR_WR_MIN_NS     3700000
`define FLR_WR_MAX_NS     4500000
`define FLR_WR_CYCLES     ((`FLR_WR_MIN_NS + `FLR_CLK_NS - 1) / `FLR_CLK_NS)

`endif

/* logic/flr_top.v */
// Purpose: self-programming control, fuse/lock/signature read-back over APB
// Assumes: eeprom_write_busy and flash_rdata come from logic on pclk
// Notes:   loads and stores of the core arrive as writes to LOAD and STORE
`timescale 1ns/100ps
`include "flr_regs.vh"

// How it works
// R1: flash programming commands are ignored while the EEPROM is being written.
// R2: fuse and lock read-back is refused while the EEPROM is being written.
// R3: software should poll EEPROM busy before writing the control register.
// R4: pointer 1 with lockfuse select and enable returns lock bits in bits 5..0.
// R5: read selects self-clear after read, no load in 3 or no store in 4.
// R6: with selects clear, a load returns ordinary flash contents.
// R7: pointer 0 with lockfuse select returns the full fuse low byte.
// R8: pointer 3 with lockfuse select returns the full fuse high byte.
// R9: pointer 2 with lockfuse select returns extended fuse in bits 2..0.
// R10: programmed cells read as zero, unprogrammed as one.
// R11: signature select and enable then a timely load return the signature byte.
// R12: signature select self-clears after the read or with no load in 3 cycles.
// R13: identification bytes one to three sit at pointer 0, 2 and 4.
// R14: pointer 1 in the signature row returns the oscillator calibration byte.
// R15: a flash write in progress completes through a system reset.
// R16: erase, page write and lock write last between 3.7 and 4.5 ms.
// R17: software polls the enable bit clear before the next command.
// R18: read-while-write section unreadable while busy until re-enable command.
// R19: software masks interrupts around the timed control write.
// R20: undefined upper bits of lock and extended fuse bytes read as one.
module flr_top #(
    parameter        WR_CYCLES    = `FLR_WR_CYCLES,
    parameter [15:0] RWW_END      = 16'hDFFF,
    parameter [7:0]  FUSE_LOW     = 8'h62,
    parameter [7:0]  FUSE_HIGH    = 8'h99,
    parameter [2:0]  FUSE_EXT     = 3'h7,
    parameter [7:0]  SIG_BYTE1    = 8'h5A, // arbitrary value
    parameter [7:0]  SIG_BYTE2    = 8'hA5, // arbitrary value
    parameter [7:0]  SIG_BYTE3    = 8'h3C, // arbitrary value
    parameter [7:0]  CAL_BYTE     = 8'h80
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        por_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        eeprom_write_busy,
    input  wire [7:0]  flash_rdata,
    output wire [15:0] flash_addr,
    output reg         flash_erase_start,
    output reg         flash_write_start,
    output reg  [15:0] flash_page_addr,
    output wire        flash_busy,
    output reg  [5:0]  lock_bits
);

    // ****************************************
    // declarations
    // ****************************************
    reg  [7:0]  ctrl;
    reg  [15:0] ptr;
    reg  [8:0]  result;
    reg  [2:0]  win_cnt;
    reg  [1:0]  op_kind;
    reg  [5:0]  lock_new;
    reg         rww_busy;
    reg  [7:0]  next_data;
    reg         next_cfg;
    wire        acc;
    wire        wr;
    wire        rd;
    wire        hit;
    wire        op_start;
    wire        op_busy;
    wire        op_done;
    wire        armed;
    wire        do_load;
    wire        do_store;
    wire        cfg_read;
    wire        win_limit;

    localparam [1:0] OP_ERASE = 2'h0;
    localparam [1:0] OP_WRITE = 2'h1;
    localparam [1:0] OP_LOCK  = 2'h2;

    // ****************************************
    // APB slave: one wait state, registered answer
    // ****************************************
    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign hit = (paddr == `FLR_OFS_CTRL)  || (paddr == `FLR_OFS_PTR)
              || (paddr == `FLR_OFS_LOAD)  || (paddr == `FLR_OFS_STORE)
              || (paddr == `FLR_OFS_RESULT)|| (paddr == `FLR_OFS_STATUS);

    // ready rises in the second access cycle and drops after it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `FLR_OFS_CTRL:   prdata <= {24'h000000, ctrl[7], rww_busy, ctrl[5:0]};
                    `FLR_OFS_PTR:    prdata <= {16'h0000, ptr};
                    `FLR_OFS_RESULT: prdata <= {23'h000000, result};
                    `FLR_OFS_STATUS: prdata <= {24'h000000, 2'h0, lock_bits};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // core instruction decode
    // ****************************************
    // a command is live while enable is set and no timed write is running
    assign armed     = ctrl[`FLR_B_SPEN] && !op_busy;
    assign do_load   = wr && (paddr == `FLR_OFS_LOAD);
    assign do_store  = wr && (paddr == `FLR_OFS_STORE) && armed
                    && (win_cnt < `FLR_STORE_WIN);
    assign cfg_read  = armed && (ctrl[`FLR_B_LFSEL] || ctrl[`FLR_B_SIGSEL])
                    && (win_cnt < `FLR_LOAD_WIN)
                    && !eeprom_write_busy;                         // see R2
    // signature select has no store use, so its window ends at three
    assign win_limit = ctrl[`FLR_B_SIGSEL] ? (win_cnt + 3'h1 == `FLR_LOAD_WIN)
                                           : (win_cnt + 3'h1 == `FLR_STORE_WIN);
    assign op_start  = do_store && !ctrl[`FLR_B_SIGSEL]
                    && (ctrl[`FLR_B_ERASE] || ctrl[`FLR_B_WRITE] || ctrl[`FLR_B_LFSEL]);
    assign flash_addr = ptr;

    // ****************************************
    // load data select
    // ****************************************
    always @* begin
        next_cfg  = 1'b0;
        next_data = flash_rdata;                                   // see R6
        if (cfg_read && ctrl[`FLR_B_SIGSEL]) begin
            next_cfg = 1'b1;
            case (ptr)
                `FLR_PTR_SIG1: next_data = SIG_BYTE1;              // see R13
                `FLR_PTR_CAL:  next_data = CAL_BYTE;               // see R14
                `FLR_PTR_SIG2: next_data = SIG_BYTE2;              // see R13
                `FLR_PTR_SIG3: next_data = SIG_BYTE3;              // see R13
                default:       next_data = `FLR_BLANK;             // see R11
            endcase
        end else if (cfg_read) begin
            next_cfg = 1'b1;
            // stored values are already zero for programmed cells, see R10
            // undefined upper bits are filled with ones, see R20
            case (ptr)
                `FLR_PTR_LOCK:      next_data = `FLR_LOCK_FILL | {2'h0, lock_bits}; // see R4
                `FLR_PTR_FUSE_LOW:  next_data = FUSE_LOW;          // see R7
                `FLR_PTR_FUSE_HIGH: next_data = FUSE_HIGH;         // see R8
                `FLR_PTR_FUSE_EXT:  next_data = `FLR_EXT_FILL | {5'h00, FUSE_EXT}; // see R9
                default:            next_data = `FLR_BLANK;
            endcase
        end else if (rww_busy && (ptr <= RWW_END)) begin
            next_data = `FLR_BLANK;                                // see R18
        end
    end

    // ****************************************
    // control register, window counter, pointer
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= `FLR_CTRL_RST;
            ptr     <= 16'h0000;
            result  <= 9'h000;
            win_cnt <= 3'h0;
        end else begin
            if (wr && (paddr == `FLR_OFS_PTR)) begin
                ptr <= pwdata[15:0];
            end
            if (do_load) begin
                result <= {next_cfg, next_data};
            end
            if (wr && (paddr == `FLR_OFS_CTRL)) begin
                // the whole write is dropped during an EEPROM write
                if (!eeprom_write_busy && !op_busy && !ctrl[`FLR_B_SPEN]) begin // see R1
                    ctrl    <= {2'h0, pwdata[5:0]};
                    win_cnt <= 3'h0;
                end
            end else if (op_busy) begin
                // enable stays set while the write runs, see R17
                ctrl <= ctrl;
            end else if (ctrl[`FLR_B_SPEN] && op_done) begin
                ctrl <= `FLR_CTRL_RST;
            end else if (armed) begin
                if (do_load && (ctrl[`FLR_B_LFSEL] || ctrl[`FLR_B_SIGSEL])) begin
                    ctrl <= `FLR_CTRL_RST;                         // see R5 R12
                end else if (do_store && !op_start) begin
                    ctrl <= `FLR_CTRL_RST;
                end else if (op_start) begin
                    ctrl <= ctrl;
                end else if (win_limit) begin
                    ctrl <= `FLR_CTRL_RST;                         // see R5 R12
                end else begin
                    win_cnt <= win_cnt + 3'h1;
                end
            end
        end
    end

    // ****************************************
    // flash write supervision on power-on reset
    // ****************************************
    // a system reset must not abandon a running write, see R15
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            op_kind           <= OP_ERASE;
            lock_new          <= `FLR_LOCK_RST;
            rww_busy          <= 1'b0;
            lock_bits         <= `FLR_LOCK_RST;
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
            flash_page_addr   <= 16'h0000;
        end else begin
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
            if (op_start) begin
                flash_page_addr <= ptr;
                lock_new        <= pwdata[5:0];
                if (ctrl[`FLR_B_LFSEL]) begin
                    op_kind <= OP_LOCK;                            // whole flash stays readable
                end else if (ctrl[`FLR_B_ERASE]) begin
                    op_kind           <= OP_ERASE;
                    flash_erase_start <= 1'b1;
                    rww_busy          <= 1'b1;                     // see R18
                end else begin
                    op_kind           <= OP_WRITE;
                    flash_write_start <= 1'b1;
                    rww_busy          <= 1'b1;                     // see R18
                end
            end else if (do_store && ctrl[`FLR_B_RWWRE] && !op_busy) begin
                rww_busy <= 1'b0;                                  // see R18
            end
            if (op_done && (op_kind == OP_LOCK)) begin
                lock_bits <= lock_bits & lock_new;                 // programming only clears
            end
        end
    end

    // ****************************************
    // write timer
    // ****************************************
    flr_op_timer #(
        .CYCLES (WR_CYCLES)
    ) u_timer (
        .pclk  (pclk),
        .por_n (por_n),
        .start (op_start),                                         // see R16
        .busy  (op_busy),
        .done  (op_done)
    );

    assign flash_busy = op_busy;

endmodule // flr_top

/* sim/flr_chk.sv */
// Purpose: port-level checks of bus handshake and timed writes
// Assumes: one clock; presetn for the bus, por_n for the write timer
// Notes:   bound into flr_top from the testbench file
`timescale 1ns/100ps
module flr_chk #(
    parameter WR_CYCLES = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        por_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        flash_erase_start,
    input wire        flash_write_start,
    input wire [15:0] flash_page_addr,
    input wire        flash_busy,
    input wire [5:0]  lock_bits
);
    int blen;
    default clocking @(posedge pclk); endclocking
    // busy run length, cleared by por_n only like the timer
    always @(posedge pclk or negedge por_n)
        if (!por_n) blen <= 0;
        else blen <= flash_busy ? blen + 1 : 0;
    sequence s_setup; psel && !penable; endsequence
    sequence s_acc; psel && penable; endsequence
    AST_ONE_WAIT: assert property (disable iff (!presetn)
        s_setup ##1 s_acc |-> !pready ##1 pready) else $error("wait state count wrong");
    AST_READY_PULSE: assert property (disable iff (!presetn) pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_PHASE: assert property (disable iff (!presetn) pslverr |-> pready and s_acc)
        else $error("error outside access");
    AST_ERR_DATA: assert property (disable iff (!presetn) pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    AST_START_PULSE: assert property (disable iff (!por_n)
        flash_erase_start || flash_write_start |=> !flash_erase_start && !flash_write_start)
        else $error("start not a pulse");
    AST_WR_LEN: assert property (disable iff (!por_n) $fell(flash_busy) |->
        blen >= WR_CYCLES - 1 && blen <= WR_CYCLES + 1) else $error("write time wrong");
    AST_WR_HOLD: assert property (disable iff (!por_n)
        flash_busy && blen < WR_CYCLES - 2 |=> flash_busy) else $error("write cut short");
    AST_PAGE_STABLE: assert property (disable iff (!por_n)
        flash_busy ##1 flash_busy |-> $stable(flash_page_addr)) else $error("page moved");
    AST_LOCK_ONEWAY: assert property (disable iff (!por_n)
        1'b1 |=> (lock_bits & ~$past(lock_bits)) == 6'h00) else $error("lock bit erased");
    AST_LOCK_TIMED: assert property (disable iff (!por_n)
        $changed(lock_bits) |-> $past(flash_busy) || $past(flash_busy, 2))
        else $error("lock change untimed");
endmodule // flr_chk

/* sim/flr_flash_model.sv */
// Purpose: ordinary flash array seen by the program load path
// Assumes: combinational read, one byte per address
// Notes:   content is a fold of the address so every byte is known
`timescale 1ns/100ps
module flr_flash_model (
    input  wire  [15:0] flash_addr,
    output logic [7:0]  flash_rdata
);
    // xor fold keeps neighbouring bytes distinct except at 7FFF and 8000
    assign flash_rdata = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
endmodule // flr_flash_model

/* sim/testbench.sv */
// Purpose: self-checking bench of the read-back unit over APB
// Assumes: 100 MHz pclk, short write timer
// Notes:   random pointers and table picks from a fixed seed
`timescale 1ns/100ps
`include "flr_regs.vh"
module testbench;
    localparam WR = 20;
    logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        eeprom_write_busy = 0, pready, pslverr, rerr, flash_busy, fes, fws;
    logic [7:0]  paddr = 8'h00, flash_rdata;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [15:0] flash_addr, flash_page_addr, p;
    logic [5:0]  lock_bits;
    int          n_fail = 0, num_checks = 0, cyc = 0, blen = 0, last_len = 0, i;
    logic [15:0] tp[9] = '{16'h1, 16'h0, 16'h3, 16'h2, 16'h0, 16'h2, 16'h4, 16'h1, 16'h3};
    logic [7:0]  tc[9] = '{8'h09, 8'h09, 8'h09, 8'h09, 8'h21, 8'h21, 8'h21, 8'h21, 8'h21};
    logic [31:0] te[9] = '{32'h1FF, 32'h162, 32'h199, 32'h1FF, 32'h15A, 32'h1A5, 32'h13C,
                           32'h180, 32'h1FF};
    flr_top #(.WR_CYCLES(WR)) i_flr_top (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .eeprom_write_busy, .flash_rdata,
        .flash_addr, .flash_erase_start(fes), .flash_write_start(fws), .flash_page_addr,
        .flash_busy, .lock_bits);
    flr_flash_model i_flr_flash_model (.flash_addr, .flash_rdata);
    initial forever #5 pclk = ~pclk;
    // ****************
    // helpers
    // ****************
    // run length of timed writes, plus the hang limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (flash_busy) blen <= blen + 1;
        else if (blen != 0) begin
            last_len <= blen;
            blen <= 0;
        end
        if (cyc == 20000) begin
            n_fail++;
            give_verdict;
        end
    end
    function logic [31:0] fl(input logic [15:0] a);
        return {24'h0, a[7:0] ^ a[15:8] ^ 8'h3C};
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // request held until ready is sampled high at a rising edge; data taken there
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1'b1;
        t = 0;
        do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 40);
        rdat = prdata; rerr = pslverr;
    endtask
    task idle; psel <= 1'b0; penable <= 1'b0; @(posedge pclk); endtask
    // back to back so the load lands inside the select window
    // nothing can cut in between the control write and the load
    task ld(input logic [15:0] a, input logic [7:0] c);
        apb(1, `FLR_OFS_PTR, {16'h0, a});
        if (c != 8'h00) apb(1, `FLR_OFS_CTRL, {24'h0, c});
        apb(1, `FLR_OFS_LOAD, 0); apb(0, `FLR_OFS_RESULT, 0); idle;
    endtask
    task wait_done;
        int t;
        t = 0;
        while (flash_busy !== 1'b0 && t < 100) begin @(posedge pclk); t++; end
        t = 0;
        do begin apb(0, `FLR_OFS_CTRL, 0); t++; end while (rdat[0] !== 1'b0 && t < 20);
        idle;
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(36642));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1; por_n <= 1'b1; @(posedge pclk);
        apb(0, `FLR_OFS_CTRL, 0); chk(rdat, 32'h0);
        apb(0, `FLR_OFS_STATUS, 0); idle; chk(rdat, 32'h3F);
        for (i = 0; i < 9; i++) begin ld(tp[i], tc[i]); chk(rdat, te[i]); end
        ld(16'h3, 8'h00); chk(rdat, fl(16'h3));
        for (i = 0; i < 2; i++) begin
            apb(1, `FLR_OFS_CTRL, i ? 32'h21 : 32'h09); idle; repeat (5) @(posedge pclk);
            apb(0, `FLR_OFS_CTRL, 0); chk(rdat, 32'h0);
            apb(1, `FLR_OFS_LOAD, 0); apb(0, `FLR_OFS_RESULT, 0); idle; chk(rdat, fl(16'h3));
        end
        eeprom_write_busy <= 1'b1;
        ld(16'h0, 8'h09); chk(rdat, fl(16'h0));
        apb(1, `FLR_OFS_CTRL, 32'h05); apb(1, `FLR_OFS_STORE, 0); idle;
        repeat (4) @(posedge pclk); chk(flash_busy, 1'b0);
        eeprom_write_busy <= 1'b0;
        apb(1, `FLR_OFS_PTR, 1); apb(1, `FLR_OFS_CTRL, 9); apb(1, `FLR_OFS_STORE, 32'h3C); idle;
        repeat (3) @(posedge pclk); presetn <= 1'b0; repeat (3) @(posedge pclk); presetn <= 1'b1;
        wait_done; chk(last_len >= WR - 1 && last_len <= WR + 1, 1);
        apb(0, `FLR_OFS_STATUS, 0); idle; chk(rdat, 32'h3C);
        te[0] = 32'h1FC;
        ld(16'h1, 8'h09); chk(rdat, te[0]);
        for (i = 0; i < 2; i++) begin
            apb(1, `FLR_OFS_PTR, 32'h100); apb(1, `FLR_OFS_CTRL, i ? 32'h05 : 32'h03);
            apb(1, `FLR_OFS_STORE, 0); idle; wait_done; chk(flash_page_addr, 32'h100);
            apb(0, `FLR_OFS_CTRL, 0); idle; chk(rdat[6], 1'b1);
            ld(16'h100, 8'h00); chk(rdat, 32'hFF);
            apb(1, `FLR_OFS_CTRL, 32'h11); apb(1, `FLR_OFS_STORE, 0); idle; wait_done;
            ld(16'h100, 8'h00); chk(rdat, fl(16'h100));
        end
        repeat (8) begin
            i = $urandom_range(8);
            ld(tp[i], tc[i]); chk(rdat, te[i]);
            p = $urandom;
            ld(p, 8'h00); chk(rdat, fl(p));
        end
        apb(1, 8'h1C, 32'hFFFF); apb(0, 8'h1C, 0); idle; chk(rerr, 1'b1); chk(rdat, 32'h0);
        give_verdict;
    end
endmodule // testbench
bind flr_top flr_chk #(.WR_CYCLES(WR_CYCLES)) i_flr_chk (.pclk, .presetn, .por_n, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .flash_erase_start, .flash_write_start,
    .flash_page_addr, .flash_busy, .lock_bits);
